// [logic/oors_regs.svh]
// Sequencer constants: offsets, fields, resets, timing.
// Assumes a 40 MHz mclk.
//
// Contract
// - Peak-drop switch, enabled after reset.
// - Peak-drop step 1,2,3,5,6,9,12,15; default 1.
// - Drop rate per 4,2,1,0.5 symbols; default 4.
// - Gain-control switch, on after reset.
// - Preamble 1-4 bytes, default 2, wake-on-radio only.
// - 8-bit successive-approximation strength digitizer feeds demodulation.
// - 1 kHz oscillator clocks sleep timer, wakes device.
// - Duty-cycle sleep 3 to 134152192 ms.
// - Oscillator calibrated at power-up, then periodically, 1%.
// - One switch selects always-receive or duty-cycle.
// - Power-up releases reset, starts crystal, calibrates.
// - Power-up lasts 4 ms or 9.5 ms.
// - Oscillator and timer off in always-receive mode.
// - Sleep powers down everything but sleep timer.
// - Sleep 3 ms always-receive, configured in duty-cycle.
// - Crystal settling only in duty-cycle, after wake.
// - Tune synthesizer about 300 us, then receive.
// - Receive state drives demodulated data pin.
// - Duty-cycle receive lasts configured receive duration.
// - Duty-cycle repeats sleep, settle, tune, receive forever.
// - Always-receive sleeps 3 ms, tunes, receives forever.
// - Crystal wait 78,155,310,620,1240,2480 us.
// - Receive and extended durations 0.04 to 2683043 ms.
`ifndef OORS_REGS_SVH
`define OORS_REGS_SVH

// Clock rate
`define OORS_MCLK_HZ          40000000
`define OORS_CYC_PER_US       (`OORS_MCLK_HZ / 1000000)

// Register indices on the plain port
`define OORS_REG_CTRL         4'h0
`define OORS_REG_SLEEP        4'h1
`define OORS_REG_RXTIME       4'h2
`define OORS_REG_RXEXT        4'h3
`define OORS_REG_SYMBOL       4'h4
`define OORS_REG_STATUS       4'h5
`define OORS_REG_CMD          4'h6

// Control field positions
`define OORS_CTRL_DUTY        0
`define OORS_CTRL_DROP_EN     1
`define OORS_CTRL_AGC         2
`define OORS_CTRL_WOR         3
`define OORS_CTRL_PRE_LO      4
`define OORS_CTRL_STEP_LO     6
`define OORS_CTRL_RATE_LO     9
`define OORS_CTRL_XTAL_LO     11
`define OORS_CMD_RESTART      0

// Reset values
`define OORS_CTRL_RESET       32'h0000_1017
`define OORS_SLEEP_RESET      28'h000_0003
`define OORS_SLEEP_MIN_MS     28'h000_0003
`define OORS_RXTIME_RESET     28'h000_C350
`define OORS_RXEXT_RESET      28'h000_1388
`define OORS_SYMBOL_RESET     16'h411B

// Peak-drop steps packed one nibble per code, code 0 in the low nibble
`define OORS_DROP_STEPS       32'hFC96_5321

// Timing in printed units, cycles derived from the rate
`define OORS_POR_US           100
`define OORS_POR_CYC          (`OORS_POR_US * `OORS_CYC_PER_US)
`define OORS_PUP_ALWAYS_US    4000
`define OORS_PUP_ALWAYS_CYC   (`OORS_PUP_ALWAYS_US * `OORS_CYC_PER_US)
`define OORS_PUP_DUTY_US      9500
`define OORS_PUP_DUTY_CYC     (`OORS_PUP_DUTY_US * `OORS_CYC_PER_US)
`define OORS_SLEEP_FIX_US     3000
`define OORS_SLEEP_FIX_CYC    (`OORS_SLEEP_FIX_US * `OORS_CYC_PER_US)
`define OORS_TUNE_US          300
`define OORS_TUNE_CYC         (`OORS_TUNE_US * `OORS_CYC_PER_US)
`define OORS_RX_UNIT_US       40
`define OORS_RX_UNIT_CYC      (`OORS_RX_UNIT_US * `OORS_CYC_PER_US)
`define OORS_XTAL0_US         78
`define OORS_XTAL1_US         155
`define OORS_XTAL2_US         310
`define OORS_XTAL3_US         620
`define OORS_XTAL4_US         1240
`define OORS_XTAL5_US         2480

// Oscillator calibration: nominal period at 1 kHz and 1 percent window
`define OORS_LPO_NOM_CYC      (`OORS_MCLK_HZ / 1000)
`define OORS_LPO_TOL_CYC      (`OORS_LPO_NOM_CYC / 100)
`define OORS_CAL_EVERY_TICKS  1000
`define OORS_TRIM_RESET       8'h80

// Digitizer settle per bit: two synchroniser flops plus one
`define OORS_SAR_SETTLE_CYC   3

`endif

// [logic/oors_pkg.sv]
// Types of the OOK receiver operation sequencer.
// Assumes the constants header is included alongside where numbers are needed.
package oors_pkg;

  // Operating states of the sequencer
  typedef enum logic [2:0] {
    OORS_PUP   = 3'b000,
    OORS_SLEEP = 3'b001,
    OORS_XTAL  = 3'b010,
    OORS_TUNE  = 3'b011,
    OORS_RX    = 3'b100
  } oors_state_e;

endpackage

// [logic/oors_sar.sv]
// Eight-bit successive-approximation digitizer of the signal strength level.
// Assumes compIn is high while the level exceeds dacCode.
`include "oors_regs.svh"

module oors_sar (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       compIn,
  output logic [7:0]      dacCode,
  output logic [7:0]      result,
  output logic            done,
  output logic            busy
);

  logic       compSync1;  // First synchroniser flop
  logic       compSync2;  // Comparator, safe to read
  logic [2:0] bitIdx;     // Bit under trial, MSB first
  logic [1:0] waitCnt;    // Settle wait per bit

  // Comparator crosses from the analog domain
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      compSync1 <= 1'b0;
      compSync2 <= 1'b0;
    end else begin
      compSync1 <= compIn;
      compSync2 <= compSync1;
    end
  end

  // One trial bit per settle window
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      dacCode <= 8'h00;
      result  <= 8'h00;
      bitIdx  <= 3'h7;
      waitCnt <= 2'h0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin  // Begin with only the MSB set
          busy    <= 1'b1;
          bitIdx  <= 3'h7;
          waitCnt <= 2'h0;
          dacCode <= 8'h80;
        end
      end else if (waitCnt != 2'(`OORS_SAR_SETTLE_CYC - 1)) begin
        waitCnt <= waitCnt + 2'h1;
      end else begin
        waitCnt <= 2'h0;
        if (bitIdx == 3'h0) begin  // Last decision ends the conversion
          busy    <= 1'b0;
          done    <= 1'b1;
          result  <= {dacCode[7:1], compSync2};
          dacCode <= 8'h00;
        end else begin  // Keep or drop this bit, then trial the next
          dacCode[bitIdx]        <= compSync2;
          dacCode[bitIdx - 3'h1] <= 1'b1;
          bitIdx                 <= bitIdx - 3'h1;
        end
      end
    end
  end

endmodule

// [logic/oors_sequencer.sv]
// OOK receiver sequencer with its demodulator core.
// Assumes a 40 MHz mclk, a raw 1 kHz oscillator and an async comparator;
// extendHit comes from logic on mclk.
`include "oors_regs.svh"

module oors_sequencer #(
  parameter int unsigned PUP_ALWAYS_CYC = `OORS_PUP_ALWAYS_CYC,
  parameter int unsigned PUP_DUTY_CYC   = `OORS_PUP_DUTY_CYC,
  parameter int unsigned SLEEP_FIX_CYC  = `OORS_SLEEP_FIX_CYC,
  parameter int unsigned TUNE_CYC       = `OORS_TUNE_CYC,
  parameter int unsigned XTAL0_CYC      = `OORS_XTAL0_US * `OORS_CYC_PER_US,
  parameter int unsigned XTAL1_CYC      = `OORS_XTAL1_US * `OORS_CYC_PER_US,
  parameter int unsigned XTAL2_CYC      = `OORS_XTAL2_US * `OORS_CYC_PER_US,
  parameter int unsigned XTAL3_CYC      = `OORS_XTAL3_US * `OORS_CYC_PER_US,
  parameter int unsigned XTAL4_CYC      = `OORS_XTAL4_US * `OORS_CYC_PER_US,
  parameter int unsigned XTAL5_CYC      = `OORS_XTAL5_US * `OORS_CYC_PER_US,
  parameter int unsigned LPO_NOM_CYC    = `OORS_LPO_NOM_CYC
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic [3:0]         regAddr,
  input  wire logic [31:0]        regWrData,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic [31:0]             regRdData,
  input  wire logic               lpOscIn,
  input  wire logic               compIn,
  input  wire logic               extendHit,
  output oors_pkg::oors_state_e   seqState,
  output logic                    porRelease,
  output logic                    xtalEn,
  output logic                    blocksPowered,
  output logic                    synthTune,
  output logic                    rxEn,
  output logic                    lpoEn,
  output logic [7:0]              lpoTrim,
  output logic                    agcEn,
  output logic [1:0]              preambleCode,
  output logic [7:0]              sarDac,
  output logic                    dataOut
);
  import oors_pkg::*;

  // Configuration registers
  logic [31:0] ctrl;        // Mode, switches and selects
  logic [27:0] sleepMs;     // Duty-cycle sleep in oscillator ticks
  logic [27:0] rxUnits;     // Receive time in 40 us units
  logic [27:0] rxExtUnits;  // Extended receive time in 40 us units
  logic [15:0] symCycles;   // Symbol period in mclk cycles
  logic        restartReq;  // Write pulse that re-runs power-up

  // Sequencer state
  oors_state_e state;
  logic        modeDuty;    // Mode latched at power-up entry
  logic [19:0] cycCnt;      // Cycles within the current state
  logic [27:0] unitCnt;     // Ticks or receive units within the state
  logic        extUsed;     // Extension granted in this receive window

  // Oscillator and calibration
  logic        lpoSync1;    // First synchroniser flop
  logic        lpoSync2;    // Oscillator level, safe to read
  logic        lpoPrev;     // Previous safe level for the edge
  logic        lpoTick;     // One tick per oscillator period
  logic        calRun;      // Measurement in progress
  logic        calArmed;    // First edge of a measurement seen
  logic        calDone;     // Oscillator inside its window
  logic [16:0] calCnt;      // Cycles of one oscillator period
  logic [9:0]  tickCnt;     // Ticks since the last calibration

  // Demodulator
  logic [7:0]  sample;      // Latest digitized strength level
  logic [7:0]  peak;        // Tracked peak level
  logic [17:0] dropCnt;     // Cycles toward the next peak drop
  logic        demodBit;    // Sliced data bit
  logic [7:0]  sarResult;
  logic        sarDone;
  logic        sarBusy;

  // Derived selects
  logic [27:0] sleepTarget;
  logic [27:0] rxTarget;
  logic [17:0] dropInterval;
  logic [19:0] xtalTarget;
  logic [19:0] pupTarget;

  // Crystal wait decode; codes above five take the longest wait
  function automatic logic [19:0] xtalCycles(input logic [2:0] sel);
    case (sel)
      3'h0:    xtalCycles = 20'(XTAL0_CYC);
      3'h1:    xtalCycles = 20'(XTAL1_CYC);
      3'h2:    xtalCycles = 20'(XTAL2_CYC);
      3'h3:    xtalCycles = 20'(XTAL3_CYC);
      3'h4:    xtalCycles = 20'(XTAL4_CYC);
      default: xtalCycles = 20'(XTAL5_CYC);
    endcase
  endfunction

  // Peak-drop step decode from the packed nibble table
  function automatic logic [7:0] dropStep(input logic [2:0] sel);
    logic [31:0] steps;
    steps    = `OORS_DROP_STEPS;
    dropStep = {4'h0, steps[{sel, 2'b00} +: 4]};
  endfunction

  // Register writes; configuration survives a restart
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl       <= `OORS_CTRL_RESET;  // Peak drop and gain control on
      sleepMs    <= `OORS_SLEEP_RESET;
      rxUnits    <= `OORS_RXTIME_RESET;
      rxExtUnits <= `OORS_RXEXT_RESET;
      symCycles  <= `OORS_SYMBOL_RESET;
      restartReq <= 1'b0;
    end else begin
      restartReq <= 1'b0;
      if (regWrite) begin
        unique case (regAddr)
          `OORS_REG_CTRL:   ctrl       <= {18'h0_0000, regWrData[13:0]};
          `OORS_REG_SLEEP:  sleepMs    <= regWrData[27:0];
          `OORS_REG_RXTIME: rxUnits    <= regWrData[27:0];
          `OORS_REG_RXEXT:  rxExtUnits <= regWrData[27:0];
          `OORS_REG_SYMBOL: symCycles  <= regWrData[15:0];
          `OORS_REG_CMD:    restartReq <= regWrData[`OORS_CMD_RESTART];
          default:          ;  // Status and holes ignore writes
        endcase
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead) begin
      unique case (regAddr)
        `OORS_REG_CTRL:   regRdData <= ctrl;
        `OORS_REG_SLEEP:  regRdData <= {4'h0, sleepMs};
        `OORS_REG_RXTIME: regRdData <= {4'h0, rxUnits};
        `OORS_REG_RXEXT:  regRdData <= {4'h0, rxExtUnits};
        `OORS_REG_SYMBOL: regRdData <= {16'h0000, symCycles};
        `OORS_REG_STATUS: regRdData <= {8'h00, lpoTrim, sample, 3'h0, calDone, modeDuty, state};
        default:          regRdData <= 32'h0000_0000;  // Unmapped reads as zero
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // Targets of the timed states
  assign sleepTarget = (sleepMs < `OORS_SLEEP_MIN_MS) ? `OORS_SLEEP_MIN_MS : sleepMs;
  assign rxTarget    = extUsed ? rxExtUnits : rxUnits;
  assign xtalTarget  = xtalCycles(ctrl[`OORS_CTRL_XTAL_LO +: 3]);
  assign pupTarget   = modeDuty ? 20'(PUP_DUTY_CYC) : 20'(PUP_ALWAYS_CYC);

  // State walk; restart re-enters power-up
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state    <= OORS_PUP;
      modeDuty <= 1'(`OORS_CTRL_RESET >> `OORS_CTRL_DUTY);
      cycCnt   <= 20'h0_0000;
      unitCnt  <= 28'h000_0000;
      extUsed  <= 1'b0;
    end else if (restartReq) begin
      state    <= OORS_PUP;
      modeDuty <= ctrl[`OORS_CTRL_DUTY];
      cycCnt   <= 20'h0_0000;
      unitCnt  <= 28'h000_0000;
      extUsed  <= 1'b0;
    end else begin
      unique case (state)
        OORS_PUP: begin  // Fixed length by mode, duty-cycle calibration runs inside
          if (cycCnt == pupTarget - 20'h0_0001) begin
            state  <= OORS_SLEEP;
            cycCnt <= 20'h0_0000;
          end else begin
            cycCnt <= cycCnt + 20'h0_0001;
          end
        end
        OORS_SLEEP: begin
          if (modeDuty) begin  // Sleep timer counts oscillator ticks
            if (lpoTick) begin
              if (unitCnt >= sleepTarget - 28'h000_0001) begin
                state   <= OORS_XTAL;  // Wake into crystal settling
                unitCnt <= 28'h000_0000;
              end else begin
                unitCnt <= unitCnt + 28'h000_0001;
              end
            end
          end else if (cycCnt == 20'(SLEEP_FIX_CYC - 1)) begin  // Fixed 3 ms
            state  <= OORS_TUNE;  // No crystal settling here
            cycCnt <= 20'h0_0000;
          end else begin
            cycCnt <= cycCnt + 20'h0_0001;
          end
        end
        OORS_XTAL: begin  // Crystal restarted, wait the selected time
          if (cycCnt >= xtalTarget - 20'h0_0001) begin
            state  <= OORS_TUNE;
            cycCnt <= 20'h0_0000;
          end else begin
            cycCnt <= cycCnt + 20'h0_0001;
          end
        end
        OORS_TUNE: begin  // Synthesizer settles, then receive
          if (cycCnt == 20'(TUNE_CYC - 1)) begin
            state   <= OORS_RX;
            cycCnt  <= 20'h0_0000;
            unitCnt <= 28'h000_0000;
            extUsed <= 1'b0;
          end else begin
            cycCnt <= cycCnt + 20'h0_0001;
          end
        end
        OORS_RX: begin
          if (modeDuty) begin  // Timed window in 40 us units
            if (ctrl[`OORS_CTRL_WOR] && extendHit && !extUsed) begin
              extUsed <= 1'b1;  // One extension restarts the window
              unitCnt <= 28'h000_0000;
              cycCnt  <= 20'h0_0000;
            end else if (cycCnt == 20'(`OORS_RX_UNIT_CYC - 1)) begin
              cycCnt <= 20'h0_0000;
              if (unitCnt >= rxTarget - 28'h000_0001) begin
                state   <= OORS_SLEEP;  // Cycle repeats
                unitCnt <= 28'h000_0000;
              end else begin
                unitCnt <= unitCnt + 28'h000_0001;
              end
            end else begin
              cycCnt <= cycCnt + 20'h0_0001;
            end
          end
          // Always-receive mode stays here until reset or a restart command
        end
        default: begin  // Illegal codes recover through power-up
          state  <= OORS_PUP;
          cycCnt <= 20'h0_0000;
        end
      endcase
    end
  end

  // Oscillator sync; edge from the second flop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lpoSync1 <= 1'b0;
      lpoSync2 <= 1'b0;
      lpoPrev  <= 1'b0;
    end else begin
      lpoSync1 <= lpOscIn;
      lpoSync2 <= lpoSync1;
      lpoPrev  <= lpoSync2;
    end
  end

  assign lpoTick = lpoSync2 & ~lpoPrev & modeDuty;  // Ticks only while enabled

  // Period measured; trim until within 1 percent
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      calRun   <= 1'b0;
      calArmed <= 1'b0;
      calDone  <= 1'b0;
      calCnt   <= 17'h0_0000;
      tickCnt  <= 10'h000;
      lpoTrim  <= `OORS_TRIM_RESET;
    end else if (restartReq || !modeDuty) begin
      calRun   <= 1'b0;  // Always-receive keeps it idle
      calArmed <= 1'b0;
      calDone  <= 1'b0;
      calCnt   <= 17'h0_0000;
      tickCnt  <= 10'h000;
    end else begin
      if (lpoTick && !calRun) begin
        tickCnt <= tickCnt + 10'h001;
      end
      if (!calRun) begin  // Start at power-up and at every interval
        if ((state == OORS_PUP && !calDone) ||
            (lpoTick && tickCnt == 10'(`OORS_CAL_EVERY_TICKS - 1))) begin
          calRun   <= 1'b1;
          calArmed <= 1'b0;
          tickCnt  <= 10'h000;
        end
      end else if (!calArmed) begin
        if (lpoTick) begin
          calArmed <= 1'b1;
          calCnt   <= 17'h0_0000;
        end
      end else if (lpoTick) begin  // Period ends; judge it
        calCnt <= 17'h0_0000;
        if (calCnt > 17'(LPO_NOM_CYC + `OORS_LPO_TOL_CYC)) begin
          lpoTrim <= (lpoTrim == 8'hFF) ? lpoTrim : lpoTrim + 8'h01;  // Slow, speed up
        end else if (calCnt < 17'(LPO_NOM_CYC - `OORS_LPO_TOL_CYC)) begin
          lpoTrim <= (lpoTrim == 8'h00) ? lpoTrim : lpoTrim - 8'h01;  // Fast, slow down
        end else begin
          calRun  <= 1'b0;
          calDone <= 1'b1;
        end
      end else if (calCnt != 17'h1_FFFF) begin
        calCnt <= calCnt + 17'h0_0001;  // Saturates if the oscillator stalls
      end
    end
  end

  // Digitizer runs back to back while receiving
  oors_sar u_sar (
    .mclk    (mclk),
    .reset   (reset),
    .start   (state == OORS_RX && !sarBusy),
    .compIn  (compIn),
    .dacCode (sarDac),
    .result  (sarResult),
    .done    (sarDone),
    .busy    (sarBusy)
  );

  // Drop interval from the symbol period and rate select
  always_comb begin
    unique case (ctrl[`OORS_CTRL_RATE_LO +: 2])
      2'h0: dropInterval = {symCycles, 2'b00};
      2'h1: dropInterval = {1'b0, symCycles, 1'b0};
      2'h2: dropInterval = {2'b00, symCycles};
      2'h3: dropInterval = {3'b000, symCycles[15:1]};
    endcase
  end

  // Peak tracking; a higher sample beats a drop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sample   <= 8'h00;
      peak     <= 8'h00;
      dropCnt  <= 18'h0_0000;
      demodBit <= 1'b0;
    end else if (state != OORS_RX) begin
      peak     <= 8'h00;  // Fresh peak per receive window
      dropCnt  <= 18'h0_0000;
      demodBit <= 1'b0;
    end else begin
      if (dropCnt >= dropInterval - 18'h0_0001) begin
        dropCnt <= 18'h0_0000;
      end else begin
        dropCnt <= dropCnt + 18'h0_0001;
      end
      if (sarDone) begin
        sample   <= sarResult;
        demodBit <= (sarResult >= {1'b0, peak[7:1]}) && (sarResult != 8'h00);
      end
      if (sarDone && sarResult > peak) begin
        peak <= sarResult;
      end else if (ctrl[`OORS_CTRL_DROP_EN] && dropCnt >= dropInterval - 18'h0_0001) begin
        // Step table
        peak <= (peak > dropStep(ctrl[`OORS_CTRL_STEP_LO +: 3])) ?
                peak - dropStep(ctrl[`OORS_CTRL_STEP_LO +: 3]) : 8'h00;
      end
    end
  end

  // Outputs registered, one cycle behind the state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seqState      <= OORS_PUP;
      porRelease    <= 1'b0;
      xtalEn        <= 1'b0;
      blocksPowered <= 1'b0;
      synthTune     <= 1'b0;
      rxEn          <= 1'b0;
      lpoEn         <= 1'b0;
      agcEn         <= 1'b0;
      preambleCode  <= 2'h0;
      dataOut       <= 1'b0;
    end else begin
      seqState      <= state;
      porRelease    <= (state != OORS_PUP) || (cycCnt >= 20'(`OORS_POR_CYC));
      xtalEn        <= (state == OORS_PUP) ? (cycCnt >= 20'(`OORS_POR_CYC))
                                           : (state != OORS_SLEEP);
      blocksPowered <= (state != OORS_SLEEP);  // Only the sleep timer stays up
      synthTune     <= (state == OORS_TUNE);
      rxEn          <= (state == OORS_RX);
      lpoEn         <= modeDuty;
      agcEn         <= ctrl[`OORS_CTRL_AGC] && (state != OORS_SLEEP);
      preambleCode  <= ctrl[`OORS_CTRL_WOR] ? ctrl[`OORS_CTRL_PRE_LO +: 2] : 2'h1;
      dataOut       <= (state == OORS_RX) && demodBit;
    end
  end

endmodule

// [tb/oors_mcu_model.sv]
// Watcher model of the controller on the demodulated data pin.
// Assumes dataOut settled by negedge.
module oors_mcu_model (
  input  wire logic mclk,
  input  wire logic dataOut,
  output int        highCnt
);
  timeunit 1ns;
  timeprecision 100ps;
  initial highCnt = 0;
  // Count high data cycles
  always @(negedge mclk) if (dataOut === 1'b1) highCnt <= highCnt + 1;
endmodule

// [tb/oors_seq_checker.sv]
// Checker of state timing at the sequencer ports.
// Assumes the bind passes the instance counts.
module oors_seq_checker
  import oors_pkg::*;
#(
  parameter int unsigned PUP_ALWAYS_CYC = 400,
  parameter int unsigned PUP_DUTY_CYC   = 800,
  parameter int unsigned SLEEP_FIX_CYC  = 300,
  parameter int unsigned TUNE_CYC       = 100
) (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire oors_pkg::oors_state_e seqState,
  input wire logic                  blocksPowered,
  input wire logic                  xtalEn,
  input wire logic                  synthTune,
  input wire logic                  lpoEn,
  input wire logic                  dataOut
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TuneM1 = TUNE_CYC - 1;
  localparam int SlpM1  = SLEEP_FIX_CYC - 1;
  int unsigned pupCnt;  // Power-up cycles seen
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Power-up length; slack of one for the lag
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) pupCnt <= 0;
    else pupCnt <= (seqState == OORS_PUP) ? pupCnt + 1 : 0;
  end
  chk_dout_quiet: assert property (
    seqState != OORS_RX && $past(seqState) != OORS_RX |-> !dataOut) else $error("dout");
  chk_sleep_dark: assert property (
    seqState == OORS_SLEEP |-> !blocksPowered && !xtalEn) else $error("sleep power");
  chk_tune_synth: assert property (
    seqState == OORS_TUNE |-> synthTune) else $error("synth");
  chk_xtal_order: assert property (
    $changed(seqState) && seqState == OORS_XTAL |-> $past(seqState) == OORS_SLEEP && lpoEn)
    else $error("xtal entry");
  chk_tune_len: assert property (
    $changed(seqState) && seqState == OORS_TUNE |-> ##TuneM1 seqState == OORS_TUNE
    ##1 seqState == OORS_RX) else $error("tune length");
  chk_sleep_fix: assert property (
    $changed(seqState) && seqState == OORS_SLEEP && !lpoEn |-> ##SlpM1
    seqState == OORS_SLEEP ##1 seqState == OORS_TUNE) else $error("sleep length");
  chk_pup_len: assert property (
    seqState == OORS_SLEEP && $past(seqState) == OORS_PUP |->
    pupCnt - (lpoEn ? PUP_DUTY_CYC : PUP_ALWAYS_CYC) <= 1) else $error("pup length");
  chk_rx_hold: assert property (
    $past(seqState) == OORS_RX && !lpoEn |-> seqState inside {OORS_RX, OORS_PUP})
    else $error("rx left");
endmodule
bind oors_sequencer oors_seq_checker #(.PUP_ALWAYS_CYC(PUP_ALWAYS_CYC),
  .PUP_DUTY_CYC(PUP_DUTY_CYC), .SLEEP_FIX_CYC(SLEEP_FIX_CYC), .TUNE_CYC(TUNE_CYC))
  u_chk (.mclk(mclk), .reset(reset), .seqState(seqState), .blocksPowered(blocksPowered),
  .xtalEn(xtalEn), .synthTune(synthTune), .lpoEn(lpoEn), .dataOut(dataOut));

// [tb/tb_oors_sequencer.sv]
// Sequencer bench: registers, duty, always mode, reset.
// Assumes shortened counts and a data pin watcher.
`include "oors_regs.svh"
module tb_oors_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import oors_pkg::*;
  localparam int XT = 40;  // Crystal wait of select 2
  typedef struct packed {logic [31:0] ctl; logic [1:0] pre; logic auto_gain_control;} oors_row_s;
  oors_row_s rows [5] = '{'{32'h0000_101B, 2'h1, 1'b0}, '{32'h0000_103F, 2'h3, 1'b1},
    '{32'h0000_17EF, 2'h2, 1'b1}, '{32'h0000_1215, 2'h1, 1'b1}, '{32'h0000_1017, 2'h1, 1'b1}};
  logic mclk = 0, reset = 1, regWrite = 0, regRead = 0, lpOscIn = 0, compIn = 0, ext = 0;
  logic [3:0] regAddr = 0;
  logic [31:0] regWrData = 0, regRdData, d;
  logic porRelease, xtalEn, blocksPowered, synthTune, rxEn, lpoEn, agcEn, dataOut;
  logic [7:0] lpoTrim, sarDac;
  logic [1:0] preambleCode;
  oors_state_e seqState;
  int err_total = 0, num_checks = 0, n, highCnt;
  always #12.5 mclk = ~mclk;
  // Oscillator: 800 mclk per tick
  always begin
    repeat (400) @(posedge mclk);
    lpOscIn <= ~lpOscIn;
  end
  oors_sequencer #(.PUP_ALWAYS_CYC(400), .PUP_DUTY_CYC(800), .SLEEP_FIX_CYC(300),
    .TUNE_CYC(100), .XTAL2_CYC(XT), .LPO_NOM_CYC(800)) uut (.mclk(mclk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .lpOscIn(lpOscIn), .compIn(compIn), .extendHit(ext),
    .seqState(seqState), .porRelease(porRelease), .xtalEn(xtalEn), .synthTune(synthTune),
    .blocksPowered(blocksPowered), .rxEn(rxEn), .lpoEn(lpoEn), .lpoTrim(lpoTrim),
    .agcEn(agcEn), .preambleCode(preambleCode), .sarDac(sarDac), .dataOut(dataOut));
  oors_mcu_model mcu (.mclk(mclk), .dataOut(dataOut), .highCnt(highCnt));
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    {regAddr, regWrData, regWrite} <= {a, v, 1'b1};
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  // Data stand one cycle
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    v = regRdData;
  endtask
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    $display("checks %0d bad %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait; running out ends the run
  task automatic waitst(input oors_state_e s);
    @(negedge mclk);
    for (int i = 0; i < 5000 && seqState !== s; i++) @(negedge mclk);
    if (seqState !== s) begin
      chk(1'b0, "wait");
      test_done();
    end
  endtask
  task automatic span(input oors_state_e s, output int c);
    for (c = 0; c < 5000 && seqState === s; c++) @(negedge mclk);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd(`OORS_REG_CTRL, d);
    chk(d === 32'h0000_1017, "ctrl reset");
    rd(`OORS_REG_STATUS, d);
    chk(d[3] === 1'b1 && lpoEn === 1'b1, "duty default");
    rd(4'hF, d);
    chk(d === 32'h0, "unmapped read");
    wr(`OORS_REG_RXTIME, 32'h0000_0001);
    foreach (rows[k]) begin
      wr(`OORS_REG_CTRL, rows[k].ctl);
      rd(`OORS_REG_CTRL, d);
      chk(d === rows[k].ctl && preambleCode === rows[k].pre && agcEn === rows[k].auto_gain_control, "row");
    end
    $display("test registers done");
    {compIn, ext} <= 2'b11;  // Extension refused, wake-on-radio off
    waitst(OORS_RX);
    span(OORS_RX, n);
    chk(n === 1600 && seqState === OORS_SLEEP && highCnt > 0, "duty rx");
    span(OORS_SLEEP, n);
    chk(n >= 1600 && n <= 2410 && seqState === OORS_XTAL, "duty sleep");
    span(OORS_XTAL, n);
    chk(n === XT && seqState === OORS_TUNE, "xtal wait");
    rd(`OORS_REG_STATUS, d);
    chk(d[4] === 1'b1 && d[23:16] === 8'h80, "calibration");
    waitst(OORS_RX);
    $display("test duty loop done");
    wr(`OORS_REG_CTRL, 32'h0000_1016);
    wr(`OORS_REG_CMD, 32'h0000_0001);
    waitst(OORS_SLEEP);
    span(OORS_SLEEP, n);
    chk(n === 300 && seqState === OORS_TUNE && lpoEn === 1'b0, "always sleep");
    waitst(OORS_RX);
    repeat (3000) @(negedge mclk);
    chk(seqState === OORS_RX && dataOut === 1'b1 && rxEn === 1'b1 && porRelease === 1'b1,
        "always rx");
    $display("test always mode done");
    @(posedge mclk) reset <= 1'b1;
    @(negedge mclk);
    chk(seqState === OORS_PUP && lpoTrim === 8'h80 && dataOut === 1'b0, "reset");
    chk(sarDac === 8'h00 && porRelease === 1'b0 && rxEn === 1'b0, "reset outs");
    @(posedge mclk) reset <= 1'b0;
    waitst(OORS_XTAL);
    chk(lpoEn === 1'b1, "duty after reset");
    $display("test reset done");
    test_done();
  end
endmodule
